// File: hw/sbg_pkg.sv
// Purpose: Shared constants and carriers for the serial baud generator and software reset block.
// Assumes: 32-bit register words on a plain strobe port, one 100 MHz clock.
// Notes:   Every offset, field position, reset value and count used by more than one file lives here.
package sbg_pkg;

  // ==========================================================================
  // Register offsets (byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [7:0]  SBG_OFS_MODE2      = 8'h00;
  localparam logic [7:0]  SBG_OFS_ENABLE     = 8'h04;
  localparam logic [7:0]  SBG_OFS_ERROR      = 8'h08;
  localparam logic [7:0]  SBG_OFS_BAUD_CTRL  = 8'h0C;
  localparam logic [7:0]  SBG_OFS_BAUD_K     = 8'h10;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int          SBG_SR_LSB         = 0;
  localparam int          SBG_SR_MSB         = 1;
  localparam int          SBG_TXRUN_POS      = 5;
  localparam int          SBG_RBFLL_POS      = 6;
  localparam int          SBG_TBEMP_POS      = 7;
  localparam int          SBG_RXE_POS        = 0;
  localparam int          SBG_TXE_POS        = 1;
  localparam int          SBG_UART_POS       = 2;
  localparam int          SBG_DBUF_POS       = 3;
  localparam int          SBG_OERR_POS       = 0;
  localparam int          SBG_PERR_POS       = 1;
  localparam int          SBG_FERR_POS       = 2;
  localparam int          SBG_DIV_LSB        = 0;
  localparam int          SBG_DIV_MSB        = 3;
  localparam int          SBG_CKSEL_LSB      = 4;
  localparam int          SBG_CKSEL_MSB      = 5;
  localparam int          SBG_FRAC_POS       = 6;
  localparam int          SBG_K_LSB          = 0;
  localparam int          SBG_K_MSB          = 3;

  // ==========================================================================
  // Values after reset and soft reset codes
  // ==========================================================================
  localparam logic [1:0]  SBG_SR_RST         = 2'h0;
  localparam logic [1:0]  SBG_SR_ARM         = 2'h2;
  localparam logic [1:0]  SBG_SR_FIRE        = 2'h1;
  localparam logic        SBG_TBEMP_RST      = 1'b1;
  localparam logic [6:0]  SBG_BAUD_CTRL_RST  = 7'h00;
  localparam logic [3:0]  SBG_BAUD_K_RST     = 4'h0;
  localparam logic [3:0]  SBG_ENABLE_RST     = 4'h0;
  localparam logic [2:0]  SBG_ERROR_RST      = 3'h0;

  // ==========================================================================
  // Counts
  // ==========================================================================
  localparam int          SBG_SR_DELAY       = 2;
  localparam logic [4:0]  SBG_N_ZERO_CODE    = 5'h10;
  localparam logic [4:0]  SBG_GROUP_LEN      = 5'h10;
  localparam logic [4:0]  SBG_TAP_MASK [4]   = '{5'h00, 5'h01, 5'h07, 5'h1F};

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       frac_en;
    logic [1:0] clk_sel;
    logic [3:0] divisor;
  } sbg_baud_cfg_t;

  typedef struct packed {
    logic tx_buf_written;
    logic tx_buf_drained;
    logic rx_buf_filled;
    logic rx_buf_read;
    logic tx_started;
    logic tx_finished;
    logic overrun;
    logic parity_err;
    logic framing_err;
  } sbg_evt_t;

  typedef struct packed {
    logic rx_enable;
    logic tx_enable;
    logic tx_buf_empty;
    logic rx_buf_full;
    logic tx_running;
    logic overrun;
    logic parity_err;
    logic framing_err;
  } sbg_status_t;

endpackage : sbg_pkg

// File: hw/sbg_prescaler.sv
// Purpose: Free-running prescaler that offers four tap enables to the baud generator.
// Assumes: One clock; taps 1 to 3 are one-cycle enable pulses, tap 0 is high every cycle.
// Notes:   A synchronous clear restarts all taps in phase.
`timescale 1ns/1ps
`default_nettype none
module sbg_prescaler
  import sbg_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       clr,
  output logic [3:0]      tap
);

  logic [4:0] cnt_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 5'h00;
    end else if (clr) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // ==========================================================================
  // Tap enables
  // ==========================================================================
  for (genvar i = 0; i < 4; i++) begin : g_tap
    assign tap[i] = ((cnt_r & SBG_TAP_MASK[i]) == SBG_TAP_MASK[i]);
  end

endmodule : sbg_prescaler
`default_nettype wire

// File: hw/sbg_divider.sv
// Purpose: Integer and fractional baud divider driven by a prescaler tap enable.
// Assumes: Configuration is stable while counting; clr restarts the group.
// Notes:   Fractional mode spreads the extra input period over a group of sixteen output periods.
`timescale 1ns/1ps
`default_nettype none
module sbg_divider
  import sbg_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  input  wire logic          clr,
  input  wire logic          tick_in,
  input  wire sbg_baud_cfg_t cfg,
  input  wire logic          frac_active,
  input  wire logic [3:0]    frac_k,
  output logic               baud_tick
);

  logic [4:0] cnt_r;
  logic [3:0] grp_r;
  logic [4:0] n_val;
  logic [4:0] period;
  logic       long_slot;

  // Code zero of the divisor stands for sixteen.
  assign n_val     = (cfg.divisor == 4'h0) ? SBG_N_ZERO_CODE : {1'b0, cfg.divisor};
  // The first 16-K periods of each group run one input tick longer.
  assign long_slot = frac_active && ({1'b0, grp_r} < (SBG_GROUP_LEN - {1'b0, frac_k}));
  assign period    = long_slot ? n_val + 5'h01 : n_val;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r     <= 5'h00;
      grp_r     <= 4'h0;
      baud_tick <= 1'b0;
    end else if (clr) begin
      cnt_r     <= 5'h00;
      grp_r     <= 4'h0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (tick_in) begin
        if (cnt_r >= period - 5'h01) begin
          cnt_r     <= 5'h00;
          grp_r     <= grp_r + 4'h1;
          baud_tick <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 5'h01;
        end
      end
    end
  end

endmodule : sbg_divider
`default_nettype wire

// File: hw/sbg_top.sv
// Purpose: Register file, software reset sequencer and baud generator of one serial channel.
// Assumes: Shift engines report buffer and error events as one-cycle pulses in sbg_evt_t.
// Notes:   Reads return data one cycle after the strobe; unmapped reads return zero.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sbg_top
  import sbg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire sbg_evt_t    evt,
  output sbg_status_t      status,
  output logic             uart_mode,
  output logic             double_buffer,
  output logic             soft_reset_pulse,
  output logic             baud_tick
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [1:0]        soft_reset_code_r;
  logic [SBG_SR_DELAY-1:0] sr_pipe_r;
  logic              rx_enable_r;
  logic              tx_enable_r;
  logic              uart_mode_r;
  logic              double_buffer_r;
  logic              tx_buf_empty_r;
  logic              rx_buf_full_r;
  logic              tx_running_r;
  logic              overrun_r;
  logic              parity_err_r;
  logic              framing_err_r;
  sbg_baud_cfg_t     baud_cfg_r;
  logic [3:0]        baud_k_r;
  logic [31:0]       rdata_nxt;
  logic [31:0]       rdata_r;

  logic              wr_mode2;
  logic              wr_enable;
  logic              wr_error;
  logic              wr_baud_ctrl;
  logic              wr_baud_k;
  logic              sr_recognised;
  logic              sr_execute;
  logic              frac_active;
  logic [3:0]        taps;
  logic              gen_tick;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  assign wr_mode2     = reg_wr && (reg_addr == SBG_OFS_MODE2);
  assign wr_enable    = reg_wr && (reg_addr == SBG_OFS_ENABLE);
  assign wr_error     = reg_wr && (reg_addr == SBG_OFS_ERROR);
  assign wr_baud_ctrl = reg_wr && (reg_addr == SBG_OFS_BAUD_CTRL);
  assign wr_baud_k    = reg_wr && (reg_addr == SBG_OFS_BAUD_K);

  // ==========================================================================
  // Software reset sequencer
  // ==========================================================================
  // Recognition needs the old stored code, so a single write of 01 out of reset does nothing.
  assign sr_recognised = wr_mode2
                      && (reg_wdata[SBG_SR_MSB:SBG_SR_LSB] == SBG_SR_FIRE)
                      && (soft_reset_code_r == SBG_SR_ARM);
  assign sr_execute    = sr_pipe_r[SBG_SR_DELAY-1];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_code_r <= SBG_SR_RST;
    end else if (wr_mode2) begin
      soft_reset_code_r <= reg_wdata[SBG_SR_MSB:SBG_SR_LSB];
    end
  end

  // The delay line lets a second sequence start while the first is still pending,
  // which is what a repeated sequence during a transmission relies on.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_pipe_r <= '0;
    end else begin
      sr_pipe_r <= {sr_pipe_r[SBG_SR_DELAY-2:0], sr_recognised};
    end
  end

  // ==========================================================================
  // Enables and mode bits
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_enable_r <= SBG_ENABLE_RST[SBG_RXE_POS];
      tx_enable_r <= SBG_ENABLE_RST[SBG_TXE_POS];
    end else if (sr_execute) begin
      rx_enable_r <= SBG_ENABLE_RST[SBG_RXE_POS];
      tx_enable_r <= SBG_ENABLE_RST[SBG_TXE_POS];
    end else if (wr_enable) begin
      rx_enable_r <= reg_wdata[SBG_RXE_POS];
      tx_enable_r <= reg_wdata[SBG_TXE_POS];
    end
  end

  // Mode bits are configuration, not run state, so the soft reset leaves them alone.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      uart_mode_r     <= SBG_ENABLE_RST[SBG_UART_POS];
      double_buffer_r <= SBG_ENABLE_RST[SBG_DBUF_POS];
    end else if (wr_enable) begin
      uart_mode_r     <= reg_wdata[SBG_UART_POS];
      double_buffer_r <= reg_wdata[SBG_DBUF_POS];
    end
  end

  // ==========================================================================
  // Buffer and run flags
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buf_empty_r <= SBG_TBEMP_RST;
    end else if (sr_execute) begin
      tx_buf_empty_r <= SBG_TBEMP_RST;
    end else if (evt.tx_buf_drained) begin
      tx_buf_empty_r <= 1'b1;
    end else if (evt.tx_buf_written) begin
      tx_buf_empty_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buf_full_r <= 1'b0;
    end else if (sr_execute) begin
      rx_buf_full_r <= 1'b0;
    end else if (evt.rx_buf_filled) begin
      rx_buf_full_r <= 1'b1;
    end else if (evt.rx_buf_read) begin
      rx_buf_full_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_running_r <= 1'b0;
    end else if (sr_execute) begin
      tx_running_r <= 1'b0;
    end else if (evt.tx_started) begin
      tx_running_r <= 1'b1;
    end else if (evt.tx_finished) begin
      tx_running_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Error flags
  // ==========================================================================
  // Software clears an error by writing one to it; a new error in the same cycle wins.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun_r     <= SBG_ERROR_RST[SBG_OERR_POS];
      parity_err_r  <= SBG_ERROR_RST[SBG_PERR_POS];
      framing_err_r <= SBG_ERROR_RST[SBG_FERR_POS];
    end else if (sr_execute) begin
      overrun_r     <= SBG_ERROR_RST[SBG_OERR_POS];
      parity_err_r  <= SBG_ERROR_RST[SBG_PERR_POS];
      framing_err_r <= SBG_ERROR_RST[SBG_FERR_POS];
    end else begin
      overrun_r     <= evt.overrun     | (overrun_r     & ~(wr_error & reg_wdata[SBG_OERR_POS]));
      parity_err_r  <= evt.parity_err  | (parity_err_r  & ~(wr_error & reg_wdata[SBG_PERR_POS]));
      framing_err_r <= evt.framing_err | (framing_err_r & ~(wr_error & reg_wdata[SBG_FERR_POS]));
    end
  end

  // ==========================================================================
  // Baud configuration
  // ==========================================================================
  // K is stored as written; code zero is software's to avoid and is not trapped here.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_cfg_r <= SBG_BAUD_CTRL_RST;
    end else if (wr_baud_ctrl) begin
      baud_cfg_r.frac_en <= reg_wdata[SBG_FRAC_POS];
      baud_cfg_r.clk_sel <= reg_wdata[SBG_CKSEL_MSB:SBG_CKSEL_LSB];
      baud_cfg_r.divisor <= reg_wdata[SBG_DIV_MSB:SBG_DIV_LSB];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_k_r <= SBG_BAUD_K_RST;
    end else if (wr_baud_k) begin
      baud_k_r <= reg_wdata[SBG_K_MSB:SBG_K_LSB];
    end
  end

  // ==========================================================================
  // Baud generator
  // ==========================================================================
  // Fractional division is ignored outside UART mode even when its enable is set.
  assign frac_active = baud_cfg_r.frac_en && uart_mode_r;
  assign gen_tick    = taps[baud_cfg_r.clk_sel];

  sbg_prescaler u_prescaler (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .clr     (sr_execute),
    .tap     (taps)
  );

  sbg_divider u_divider (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .clr         (sr_execute),
    .tick_in     (gen_tick),
    .cfg         (baud_cfg_r),
    .frac_active (frac_active),
    .frac_k      (baud_k_r),
    .baud_tick   (baud_tick)
  );

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        SBG_OFS_MODE2: begin
          rdata_nxt[SBG_SR_MSB:SBG_SR_LSB] = soft_reset_code_r;
          rdata_nxt[SBG_TXRUN_POS]         = tx_running_r;
          rdata_nxt[SBG_RBFLL_POS]         = rx_buf_full_r;
          rdata_nxt[SBG_TBEMP_POS]         = tx_buf_empty_r;
        end
        SBG_OFS_ENABLE: begin
          rdata_nxt[SBG_RXE_POS]  = rx_enable_r;
          rdata_nxt[SBG_TXE_POS]  = tx_enable_r;
          rdata_nxt[SBG_UART_POS] = uart_mode_r;
          rdata_nxt[SBG_DBUF_POS] = double_buffer_r;
        end
        SBG_OFS_ERROR: begin
          rdata_nxt[SBG_OERR_POS] = overrun_r;
          rdata_nxt[SBG_PERR_POS] = parity_err_r;
          rdata_nxt[SBG_FERR_POS] = framing_err_r;
        end
        SBG_OFS_BAUD_CTRL: begin
          rdata_nxt[SBG_FRAC_POS]                = baud_cfg_r.frac_en;
          rdata_nxt[SBG_CKSEL_MSB:SBG_CKSEL_LSB] = baud_cfg_r.clk_sel;
          rdata_nxt[SBG_DIV_MSB:SBG_DIV_LSB]     = baud_cfg_r.divisor;
        end
        SBG_OFS_BAUD_K: begin
          rdata_nxt[SBG_K_MSB:SBG_K_LSB] = baud_k_r;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // Data is held for exactly the cycle after the strobe and is zero otherwise.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata        = rdata_r;
  assign soft_reset_pulse = sr_execute;
  assign uart_mode        = uart_mode_r;
  assign double_buffer    = double_buffer_r;

  assign status.rx_enable    = rx_enable_r;
  assign status.tx_enable    = tx_enable_r;
  assign status.tx_buf_empty = tx_buf_empty_r;
  assign status.rx_buf_full  = rx_buf_full_r;
  assign status.tx_running   = tx_running_r;
  assign status.overrun      = overrun_r;
  assign status.parity_err   = parity_err_r;
  assign status.framing_err  = framing_err_r;

endmodule : sbg_top
`default_nettype wire

// File: bench/sbg_monitor.sv
// Purpose: Port-level checker for the serial baud generator and soft reset block.
// Assumes: Bound to sbg_top; one clock, asynchronous active-low reset.
// Notes:   Control registers are shadowed from the write strobes, never read back.
`timescale 1ns/1ps
`default_nettype none
module sbg_monitor
  import sbg_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire sbg_evt_t    evt,
  input wire sbg_status_t status,
  input wire logic        uart_mode,
  input wire logic        double_buffer,
  input wire logic        soft_reset_pulse,
  input wire logic        baud_tick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // Shadow state
  // ==========================================================================
  logic [1:0] code_r;
  logic [1:0] fire_r;
  logic [6:0] ctrl_r;
  logic       uart_r;
  logic [1:0] chg_r;
  logic [9:0] gap_r;
  logic [9:0] exp_gap;
  logic [4:0] n_val;
  logic       fire;
  logic       wr_cfg;
  logic       frac_on;

  assign fire    = reg_wr && reg_addr == SBG_OFS_MODE2 && reg_wdata[1:0] == SBG_SR_FIRE && code_r == SBG_SR_ARM;
  assign wr_cfg  = reg_wr && (reg_addr == SBG_OFS_BAUD_CTRL || reg_addr == SBG_OFS_BAUD_K || reg_addr == SBG_OFS_ENABLE);
  assign frac_on = ctrl_r[6] && uart_r;
  assign n_val   = (ctrl_r[3:0] == 4'h0) ? 5'h10 : {1'b0, ctrl_r[3:0]};

  always_comb begin
    case (ctrl_r[5:4])
      2'h0:    exp_gap = {5'h00, n_val} - 10'h001;
      2'h1:    exp_gap = {4'h0, n_val, 1'b0} - 10'h001;
      2'h2:    exp_gap = {2'h0, n_val, 3'h0} - 10'h001;
      default: exp_gap = {n_val, 5'h00} - 10'h001;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      code_r <= SBG_SR_RST;
      fire_r <= 2'h0;
      ctrl_r <= SBG_BAUD_CTRL_RST;
      uart_r <= 1'b0;
    end else begin
      fire_r <= {fire_r[0], fire};
      if (reg_wr && reg_addr == SBG_OFS_MODE2) begin
        code_r <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == SBG_OFS_BAUD_CTRL) begin
        ctrl_r <= reg_wdata[6:0];
      end
      if (reg_wr && reg_addr == SBG_OFS_ENABLE) begin
        uart_r <= reg_wdata[SBG_UART_POS];
      end
    end
  end

  // A period is only judged once two ticks have passed under an unchanged setup,
  // because the tick that follows a change still carries the old tap phase.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chg_r <= 2'h2;
      gap_r <= 10'h000;
    end else begin
      if (wr_cfg || soft_reset_pulse) begin
        chg_r <= 2'h2;
      end else if (baud_tick && chg_r != 2'h0) begin
        chg_r <= chg_r - 2'h1;
      end
      gap_r <= baud_tick ? 10'h000 : gap_r + 10'h001;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sr_fire_a: assert property (fire |-> ##2 soft_reset_pulse)
    else $error("soft reset pulse missing two cycles after the arming sequence");
  sr_cause_a: assert property (soft_reset_pulse |-> fire_r[1])
    else $error("soft reset pulse without a 10 then 01 sequence");
  sr_clear_a: assert property (soft_reset_pulse |=> status == 8'h20)
    else $error("status not at reset values after soft reset");
  mode_keep_a: assert property (soft_reset_pulse && !reg_wr |=> $stable(uart_mode) && $stable(double_buffer))
    else $error("mode bits changed by soft reset");
  baud_period_a: assert property (baud_tick && chg_r == 2'h0 && !frac_on |-> gap_r == exp_gap)
    else $error("integer baud period wrong");
  frac_period_a: assert property (baud_tick && chg_r == 2'h0 && frac_on && ctrl_r[5:4] == 2'h0
    |-> gap_r == exp_gap || gap_r == exp_gap + 10'h001)
    else $error("fractional baud period not N or N+1");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the read answer cycle");
  run_set_a: assert property (evt.tx_started && !soft_reset_pulse |=> status.tx_running)
    else $error("transmit start event did not set the running flag");
endmodule : sbg_monitor
`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench for the serial baud generator and soft reset block.
// Assumes: Register port answers reads one cycle after the strobe.
// Notes:   Baud periods are measured between ticks after the divider has settled.
`timescale 1ns/1ps
`default_nettype none
module tb
  import sbg_pkg::*;
;
  logic        sys_clk;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  sbg_evt_t    evt;
  sbg_status_t status;
  logic        uart_mode;
  logic        double_buffer;
  logic        soft_reset_pulse;
  logic        baud_tick;
  logic [31:0] rng_r;
  logic [3:0]  sr_tab [5];
  int          n_fail;
  int          checked;
  int          cycles;

  sbg_top i_sbg_top (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .status(status),
    .uart_mode(uart_mode), .double_buffer(double_buffer), .soft_reset_pulse(soft_reset_pulse),
    .baud_tick(baud_tick));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] rnd();
    rng_r = rng_r ^ (rng_r << 13);
    rng_r = rng_r ^ (rng_r >> 17);
    rng_r = rng_r ^ (rng_r << 5);
    return rng_r;
  endfunction : rnd

  task automatic test_done();
    $display("counts: checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  task automatic pev(input sbg_evt_t e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
    #1;
  endtask : pev

  task automatic next_tick(output int cyc);
    cyc = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cyc++;
    end while (baud_tick !== 1'b1 && cyc < 2000);
  endtask : next_tick

  // The first ticks after a change are dropped: they still carry the old phase.
  task automatic measure(input int np, output int tot);
    int c;
    repeat (3) next_tick(c);
    tot = 0;
    repeat (np) begin
      next_tick(c);
      tot += c;
    end
  endtask : measure

  // ==========================================================================
  // Clock, timeout and main sequence
  // ==========================================================================
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    int  t;
    int  n;
    int  k;
    logic [31:0] d;
    logic fire;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    evt = '0;
    rng_r = 32'h0000_8665;
    n_fail = 0;
    checked = 0;
    cycles = 0;
    sr_tab = '{4'h9, 4'hD, 4'h1, 4'hA, 4'h9};
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(SBG_OFS_MODE2, 32'h80);
    rd(SBG_OFS_ENABLE, 32'h0);
    rd(SBG_OFS_ERROR, 32'h0);
    rd(SBG_OFS_BAUD_CTRL, 32'h0);
    rd(SBG_OFS_BAUD_K, 32'h0);
    rd(8'hFC, 32'h0);
    repeat (8) begin
      d = rnd();
      wr(SBG_OFS_BAUD_CTRL, d);
      rd(SBG_OFS_BAUD_CTRL, d & 32'h7F);
      d = rnd() | 32'h1;
      wr(SBG_OFS_BAUD_K, d);
      rd(SBG_OFS_BAUD_K, d & 32'hF);
      wr(8'hFC, rnd());
      rd(8'hFC, 32'h0);
    end
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      fire = sr_tab[i] == 4'h9;
      wr(SBG_OFS_ENABLE, 32'hF);
      pev(9'h157);
      chk(status, 8'hDF);
      wr(SBG_OFS_MODE2, {30'h0, sr_tab[i][3:2]});
      wr(SBG_OFS_MODE2, {30'h0, sr_tab[i][1:0]});
      @(posedge sys_clk);
      #1;
      chk(soft_reset_pulse, fire);
      @(posedge sys_clk);
      #1;
      chk(status, fire ? 8'h20 : 8'hDF);
      chk({double_buffer, uart_mode}, 32'h3);
      rd(SBG_OFS_ENABLE, fire ? 32'hC : 32'hF);
      rd(SBG_OFS_ERROR, fire ? 32'h0 : 32'h7);
      rd(SBG_OFS_MODE2, (fire ? 32'h80 : 32'h60) | sr_tab[i][1:0]);
    end
    // A transmission is running, so the sequence is given twice in succession.
    pev(9'h010);
    chk(status, 8'h28);
    repeat (2) begin
      wr(SBG_OFS_MODE2, 32'h2);
      wr(SBG_OFS_MODE2, 32'h1);
    end
    repeat (2) @(posedge sys_clk);
    #1;
    chk(status, 8'h20);
    $display("test soft reset done");
    wr(SBG_OFS_ENABLE, 32'h8);
    for (int sel = 0; sel < 4; sel++) begin
      for (int j = 0; j < 3; j++) begin
        n = (j == 0) ? 0 : (j == 1) ? 1 : 2 + rnd() % 14;
        wr(SBG_OFS_BAUD_CTRL, (j == 2 ? 32'h40 : 32'h0) | (sel << 4) | n);
        measure(2, t);
        chk(t, 2 * (n == 0 ? 16 : n) * (1 << (sel == 0 ? 0 : 2 * sel - 1)));
      end
    end
    $display("test integer divider done");
    wr(SBG_OFS_ENABLE, 32'h4);
    for (int j = 0; j < 3; j++) begin
      k = (j == 0) ? 1 : (j == 1) ? 15 : 2 + rnd() % 13;
      n = 2 + rnd() % 14;
      wr(SBG_OFS_BAUD_CTRL, n);
      wr(SBG_OFS_BAUD_K, k);
      wr(SBG_OFS_BAUD_CTRL, 32'h40 | n);
      measure(16, t);
      chk(t, 16 * n + 16 - k);
    end
    $display("test fractional divider done");
    test_done();
  end
endmodule : tb

bind sbg_top sbg_monitor i_sbg_monitor (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt),
  .status(status), .uart_mode(uart_mode), .double_buffer(double_buffer),
  .soft_reset_pulse(soft_reset_pulse), .baud_tick(baud_tick));
`default_nettype wire
